// *** hw/bst_selftest_defines.svh ***
// Purpose: Constants for the board self-test logic
// Assumes: CLOCK_IN at 100 MHz, lamp vector bit n-1 drives lamp n
// Notes: Timing counts except BST_LOSS_CYCLES are derived from times in their own units
//
// Overview of operation
// RL1: One reference clock yields a system rate and a line rate twice as fast.
// RL2: Each checker repeats the ten-bit pattern 0101110011 on its differential output.
// RL3: Two bits move per system tick, one per half, doubling the line rate.
// RL4: Two identical checkers; checker one on lamp eight, checker two on lamp seven.
// RL5: Lamp flashes while own pattern returns; stays off on failure or open link.
// RL6: Lamps seven, eight forced on by reset or all-on; after reset a brief hold, then status.
// RL7: Holding the all-on button forces lamps eight to two on asynchronously.
// RL8: Releasing all-on shows 01010 on lamps six to two for one second, then zero.
// RL9: Holding the all-off button forces lamps eight to two off asynchronously.
// RL10: Releasing all-off shows 10101 on lamps six to two for one second, then zero.
// RL11: Count button starts a binary up-count on lamps six to two until overridden.
// RL12: From reset, with no button pressed the lamp controller counts; after a display it stays at zero.
// RL13: Reset button resets all logic and lights lamps eight to one while held.
// RL14: Lamp one is low except during reset, when it is forced high asynchronously.
// RL15: On reset release lamps six to one go off; seven and eight may stay on.
// RL16: Serial echo input is wired straight to serial echo output.
// RL17: A button input reads one while held and zero once released.
// RL18: A lamp output at one lights the lamp, zero switches it off.
// RL19: Checker searches all ten alignments; a full match counts as good reception.
// RL20: Displays and flashes are timed by counters on every CLOCK_IN cycle, not the system tick.
// RL21: Reset beats all-off, and all-off beats all-on.
`ifndef BST_SELFTEST_DEFINES_SVH
`define BST_SELFTEST_DEFINES_SVH

// ----------------------------------------
// Pattern and lamp values
// ----------------------------------------
`define BST_PATTERN 10'h173
`define BST_SHOW_ON_LAMPS 5'h0a
`define BST_SHOW_OFF_LAMPS 5'h15
`define BST_PATTERN_BITS 10

// ----------------------------------------
// Timing
// ----------------------------------------
`define BST_CLK_HZ 100000000
`define BST_SHOW_MS 1000
`define BST_STEP_MS 250
`define BST_FLASH_MS 125
`define BST_HOLD_MS 500
`define BST_SHOW_CYCLES ((`BST_CLK_HZ / 1000) * `BST_SHOW_MS)
`define BST_STEP_CYCLES ((`BST_CLK_HZ / 1000) * `BST_STEP_MS)
`define BST_FLASH_CYCLES ((`BST_CLK_HZ / 1000) * `BST_FLASH_MS)
`define BST_HOLD_CYCLES ((`BST_CLK_HZ / 1000) * `BST_HOLD_MS)
`define BST_LOSS_CYCLES 40

`endif

// *** hw/bst_pkg.sv ***
// Purpose: Types shared by the self-test modules
// Assumes: Nothing
// Notes: Constants live in bst_selftest_defines.svh
package bst_pkg;
	typedef logic [31:0] bst_count_t;
	typedef enum logic [1:0] {MODE_COUNT, MODE_SHOW_ON, MODE_SHOW_OFF, MODE_ZERO} bst_mode_t;
endpackage

// *** hw/bst_link_if.sv ***
// Purpose: Tick and status link between lamp controller and a checker
// Assumes: One clock domain
// Notes: sys_tick is a one-cycle enable every second clock
`timescale 1ns/1ns
interface bst_link_if;
	logic sys_tick;
	logic status;
	modport ctrl (output sys_tick, input status);
	modport chk (input sys_tick, output status);
endinterface

// *** hw/bst_loop_checker.sv ***
// Purpose: One double-rate serial loopback checker
// Assumes: rx is sampled once per clock, i.e. both halves of a system tick
// Notes: Status flashes while any alignment of the pattern keeps returning
`timescale 1ns/1ns
`include "bst_selftest_defines.svh"
module bst_loop_checker
	import bst_pkg::*;
#(
	parameter int unsigned FLASH_CYCLES = `BST_FLASH_CYCLES,
	parameter int unsigned HOLD_CYCLES = `BST_HOLD_CYCLES
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	bst_link_if.chk link,
	input wire logic rx_p_in,
	input wire logic rx_n_in,
	output logic tx_p_out,
	output logic tx_n_out
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic any_rotation(input logic [9:0] win);
		logic [9:0] rot;
		logic hit;
		rot = `BST_PATTERN;
		hit = 1'b0;
		for (int i = 0; i < `BST_PATTERN_BITS; i++) begin
			if (win == rot)
				hit = 1'b1;
			rot = {rot[8:0], rot[9]};
		end
		return hit;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [9:0] pat, next_pat;
	logic low_bit, next_low_bit;
	logic line_bit, next_line_bit;
	logic line_bit_n, next_line_bit_n;
	logic [9:0] rx_win, next_rx_win;
	bst_count_t silent, next_silent;
	bst_count_t hold, next_hold;
	bst_count_t flash_cnt, next_flash_cnt;
	logic flash, next_flash;
	logic status, next_status;
	logic match;
	logic good;

	assign match = any_rotation(rx_win);
	assign good = silent < `BST_LOSS_CYCLES;
	assign tx_p_out = line_bit;
	assign tx_n_out = line_bit_n;
	assign link.status = status;

	always_comb begin
		next_pat = pat;
		next_low_bit = low_bit;
		next_line_bit = low_bit;
		if (link.sys_tick) begin // RL3
			next_pat = {pat[7:0], pat[9:8]}; // RL2
			next_line_bit = pat[9];
			next_low_bit = pat[8];
		end
		next_line_bit_n = ~next_line_bit; // RL3
		next_rx_win = {rx_win[8:0], rx_p_in & ~rx_n_in}; // RL3
		next_silent = silent;
		if (match) // RL19
			next_silent = '0;
		else if (good)
			next_silent = silent + 32'h1;
		next_hold = (hold < HOLD_CYCLES) ? hold + 32'h1 : hold; // RL20
		next_flash_cnt = '0;
		next_flash = 1'b0;
		if (good) begin
			next_flash_cnt = flash_cnt + 32'h1;
			next_flash = flash;
			if (flash_cnt >= FLASH_CYCLES - 1) begin // RL20
				next_flash_cnt = '0;
				next_flash = ~flash;
			end
		end
		if (hold < HOLD_CYCLES)
			next_status = 1'b1; // RL6
		else
			next_status = good & flash; // RL5
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pat <= `BST_PATTERN;
			low_bit <= 1'b0;
			line_bit <= 1'b0;
			line_bit_n <= 1'b1;
			rx_win <= '0;
			silent <= `BST_LOSS_CYCLES;
			hold <= '0;
			flash_cnt <= '0;
			flash <= 1'b0;
			status <= 1'b1;
		end else begin
			pat <= next_pat;
			low_bit <= next_low_bit;
			line_bit <= next_line_bit;
			line_bit_n <= next_line_bit_n;
			rx_win <= next_rx_win;
			silent <= next_silent;
			hold <= next_hold;
			flash_cnt <= next_flash_cnt;
			flash <= next_flash;
			status <= next_status;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [3:0] age;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			age <= '0;
		else if (age != 4'hf)
			age <= age + 4'h1;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	a_tx_repeats_pattern: assert property (age == 4'hf |-> tx_p_out == $past(tx_p_out, 10)) // RL2
		else $error("tx stream does not repeat every ten bits");
	a_match_clears_loss: assert property (match |=> silent == 32'h0) // RL19
		else $error("match did not clear loss counter");
	a_loss_goes_dark: assert property (!good && hold >= HOLD_CYCLES |=> !status) // RL5
		else $error("status lit without good reception");
	a_hold_keeps_lit: assert property (hold < HOLD_CYCLES |=> status) // RL6
		else $error("status not lit during post-reset hold");
	a_pair_opposed: assert property (tx_n_out == !tx_p_out) // RL3
		else $error("tx pair legs not opposed");
endmodule // bst_loop_checker

// *** hw/bst_selftest_top.sv ***
// Purpose: Board self-test: two loopback checkers, lamp controller, serial echo
// Assumes: Buttons are synchronous to CLOCK_IN and read one while held
// Notes: The line rate is CLOCK_IN; the system rate is a half-rate tick
`timescale 1ns/1ns
`include "bst_selftest_defines.svh"
module bst_selftest_top
	import bst_pkg::*;
#(
	parameter int unsigned SHOW_CYCLES = `BST_SHOW_CYCLES,
	parameter int unsigned STEP_CYCLES = `BST_STEP_CYCLES,
	parameter int unsigned FLASH_CYCLES = `BST_FLASH_CYCLES,
	parameter int unsigned HOLD_CYCLES = `BST_HOLD_CYCLES
) (
	input wire logic CLOCK_IN,
	input wire logic RSTN_IN,
	input wire logic RESET_PUSHBUTTON_IN,
	input wire logic ALL_ON_PUSHBUTTON_IN,
	input wire logic ALL_OFF_PUSHBUTTON_IN,
	input wire logic COUNT_PUSHBUTTON_IN,
	input wire logic LOOP_ONE_DIFF_RX_P_IN,
	input wire logic LOOP_ONE_DIFF_RX_N_IN,
	input wire logic LOOP_TWO_DIFF_RX_P_IN,
	input wire logic LOOP_TWO_DIFF_RX_N_IN,
	input wire logic SERIAL_ECHO_IN,
	output logic LOOP_ONE_DIFF_TX_P_OUT,
	output logic LOOP_ONE_DIFF_TX_N_OUT,
	output logic LOOP_TWO_DIFF_TX_P_OUT,
	output logic LOOP_TWO_DIFF_TX_N_OUT,
	output logic SERIAL_ECHO_OUT,
	output logic [7:0] LAMP_DRIVE_OUT
);
	// ----------------------------------------
	// Reset and system tick
	// ----------------------------------------
	logic rst_any_n;
	logic tick_phase, next_tick_phase;
	logic sys_tick, next_sys_tick;

	assign rst_any_n = RSTN_IN & ~RESET_PUSHBUTTON_IN; // RL13
	assign SERIAL_ECHO_OUT = SERIAL_ECHO_IN; // RL16

	// Half-rate tick stands in for the system clock; the line moves two bits per tick
	always_comb begin
		next_tick_phase = ~tick_phase; // RL1
		next_sys_tick = ~tick_phase;
	end

	always_ff @(posedge CLOCK_IN or negedge rst_any_n) begin
		if (!rst_any_n) begin
			tick_phase <= 1'b0;
			sys_tick <= 1'b0;
		end else begin
			tick_phase <= next_tick_phase;
			sys_tick <= next_sys_tick;
		end
	end

	// ----------------------------------------
	// Loopback checkers
	// ----------------------------------------
	bst_link_if link_one ();
	bst_link_if link_two ();
	assign link_one.sys_tick = sys_tick;
	assign link_two.sys_tick = sys_tick;

	bst_loop_checker #(.FLASH_CYCLES(FLASH_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) chk_one (
		.clk_in(CLOCK_IN),
		.rstn_in(rst_any_n),
		.link(link_one.chk),
		.rx_p_in(LOOP_ONE_DIFF_RX_P_IN),
		.rx_n_in(LOOP_ONE_DIFF_RX_N_IN),
		.tx_p_out(LOOP_ONE_DIFF_TX_P_OUT),
		.tx_n_out(LOOP_ONE_DIFF_TX_N_OUT)
	);

	bst_loop_checker #(.FLASH_CYCLES(FLASH_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) chk_two (
		.clk_in(CLOCK_IN),
		.rstn_in(rst_any_n),
		.link(link_two.chk),
		.rx_p_in(LOOP_TWO_DIFF_RX_P_IN),
		.rx_n_in(LOOP_TWO_DIFF_RX_N_IN),
		.tx_p_out(LOOP_TWO_DIFF_TX_P_OUT),
		.tx_n_out(LOOP_TWO_DIFF_TX_N_OUT)
	);

	// ----------------------------------------
	// Lamp mode controller
	// ----------------------------------------
	bst_mode_t mode, next_mode;
	bst_count_t show_timer, next_show_timer;
	bst_count_t step_timer, next_step_timer;
	logic [4:0] count, next_count;
	logic step_tick;

	assign step_tick = step_timer >= STEP_CYCLES - 1;

	always_comb begin
		next_mode = mode;
		next_show_timer = show_timer;
		next_step_timer = step_tick ? 32'h0 : step_timer + 32'h1; // RL20
		next_count = count;
		if (ALL_OFF_PUSHBUTTON_IN) begin // RL21
			next_mode = MODE_SHOW_OFF;
			next_show_timer = '0;
		end else if (ALL_ON_PUSHBUTTON_IN) begin
			next_mode = MODE_SHOW_ON;
			next_show_timer = '0;
		end else if (COUNT_PUSHBUTTON_IN) begin // RL11
			next_mode = MODE_COUNT;
		end else begin
			unique case (mode)
				MODE_COUNT: begin
					if (step_tick)
						next_count = count + 5'h1; // RL11
				end
				MODE_SHOW_ON, MODE_SHOW_OFF: begin
					next_show_timer = show_timer + 32'h1;
					if (show_timer >= SHOW_CYCLES - 1) // RL8 RL10
						next_mode = MODE_ZERO;
				end
				MODE_ZERO: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK_IN or negedge rst_any_n) begin
		if (!rst_any_n) begin
			mode <= MODE_COUNT; // RL12
			show_timer <= '0;
			step_timer <= '0;
			count <= '0;
		end else begin
			mode <= next_mode;
			show_timer <= next_show_timer;
			step_timer <= next_step_timer;
			count <= next_count;
		end
	end

	// ----------------------------------------
	// Lamp drive
	// ----------------------------------------
	logic [7:0] next_lamp;

	always_comb begin
		next_lamp[7] = link_one.status; // RL4
		next_lamp[6] = link_two.status; // RL4
		next_lamp[0] = 1'b0; // RL14
		unique case (mode)
			MODE_COUNT: next_lamp[5:1] = count;
			MODE_SHOW_ON: next_lamp[5:1] = `BST_SHOW_ON_LAMPS; // RL8
			MODE_SHOW_OFF: next_lamp[5:1] = `BST_SHOW_OFF_LAMPS; // RL10
			MODE_ZERO: next_lamp[5:1] = 5'h00;
		endcase
	end

	// Reset, all-off and all-on buttons act on the lamp flops asynchronously, in priority order
	always_ff @(posedge CLOCK_IN or negedge rst_any_n or posedge ALL_OFF_PUSHBUTTON_IN
		or posedge ALL_ON_PUSHBUTTON_IN) begin
		if (!rst_any_n)
			LAMP_DRIVE_OUT <= 8'hff; // RL13 RL14 RL6
		else if (ALL_OFF_PUSHBUTTON_IN)
			LAMP_DRIVE_OUT <= 8'h00; // RL9 RL21
		else if (ALL_ON_PUSHBUTTON_IN)
			LAMP_DRIVE_OUT <= 8'hfe; // RL7 RL6
		else
			LAMP_DRIVE_OUT <= next_lamp; // RL18 RL15
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic no_button;
	assign no_button = !ALL_ON_PUSHBUTTON_IN && !ALL_OFF_PUSHBUTTON_IN && !COUNT_PUSHBUTTON_IN;

	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!rst_any_n);

	sequence s_on_released;
		(ALL_ON_PUSHBUTTON_IN && !ALL_OFF_PUSHBUTTON_IN) ##1 (!ALL_ON_PUSHBUTTON_IN && no_button);
	endsequence
	sequence s_off_released;
		ALL_OFF_PUSHBUTTON_IN ##1 (!ALL_OFF_PUSHBUTTON_IN && no_button);
	endsequence
	sequence s_quiet;
		no_button ##1 no_button;
	endsequence

	a_lamp_one_low: assert property ($past(rst_any_n) |-> !LAMP_DRIVE_OUT[0]) // RL14
		else $error("lamp one lit outside reset");
	a_off_forces_dark: assert property (ALL_OFF_PUSHBUTTON_IN [*2] |-> LAMP_DRIVE_OUT == 8'h00) // RL9
		else $error("all-off did not darken lamps");
	a_on_forces_lit: assert property ((ALL_ON_PUSHBUTTON_IN && !ALL_OFF_PUSHBUTTON_IN) [*2]
		|-> LAMP_DRIVE_OUT[7:1] == 7'h7f) // RL7
		else $error("all-on did not light lamps");
	a_show_on_value: assert property (s_on_released ##1 no_button
		|=> LAMP_DRIVE_OUT[5:1] == 5'h0a) // RL8
		else $error("wrong display after all-on release");
	a_show_off_value: assert property (s_off_released ##1 no_button
		|=> LAMP_DRIVE_OUT[5:1] == 5'h15) // RL10
		else $error("wrong display after all-off release");
	a_show_ends_zero: assert property ((mode == MODE_SHOW_ON || mode == MODE_SHOW_OFF)
		&& show_timer == SHOW_CYCLES - 1 && no_button |=> mode == MODE_ZERO ##1
		LAMP_DRIVE_OUT[5:1] == 5'h00) // RL8
		else $error("display did not return to zero");
	a_count_steps: assert property (mode == MODE_COUNT && step_tick && no_button
		|=> count == $past(count) + 5'h1) // RL11
		else $error("count did not advance");
	a_count_holds: assert property (!step_tick |=> count == $past(count)) // RL11
		else $error("count moved between steps");
	a_show_restarts: assert property (ALL_ON_PUSHBUTTON_IN || ALL_OFF_PUSHBUTTON_IN |=> // RL8 RL10
		show_timer == 32'h0)
		else $error("display timer not restarted while a button is held");

	// Lamps follow registered state only when no button forced them in between
	a_status_lamps: assert property (s_quiet |-> // RL4
		LAMP_DRIVE_OUT[7:6] == $past({link_one.status, link_two.status}))
		else $error("status lamps do not follow the checkers");
	a_zero_dark: assert property ((mode == MODE_ZERO && no_button) ##1 no_button |-> // RL8 RL10
		LAMP_DRIVE_OUT[5:1] == 5'h00)
		else $error("lamps not dark after display");
endmodule // bst_selftest_top

// *** test/bst_loop_partner.sv ***
// Purpose: Loopback shunt model for one differential pair
// Assumes: A fitted shunt returns the stream unchanged
// Notes: An open pair shows a level that toggles every clock, never the last value
`timescale 1ns/1ns
module bst_loop_partner (
	input wire logic clk_in,
	input wire logic connect_in,
	input wire logic tx_p_in,
	input wire logic tx_n_in,
	output logic rx_p_out,
	output logic rx_n_out
);
	logic flip = 1'b0;
	always @(posedge clk_in) begin
		flip <= ~flip;
	end
	// Both legs equal while open, so the received bit never carries the pattern
	assign rx_p_out = connect_in ? tx_p_in : flip;
	assign rx_n_out = connect_in ? tx_n_in : flip;
endmodule // bst_loop_partner

// *** test/board_selftest_switch_led_loopback_tb_top.sv ***
// Purpose: Self-checking bench for the board self-test logic
// Assumes: Short timing parameters; one clock at 100 MHz
// Notes: Both pairs are looped back through shunt models
`timescale 1ns/1ns
module board_selftest_switch_led_loopback_tb_top;
	localparam int SHOW = 20;
	localparam int STEP = 4;
	localparam int FLASH = 8;
	localparam int HOLD = 30;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic b_rst = 1'b0;
	logic b_on = 1'b0;
	logic b_off = 1'b0;
	logic b_cnt = 1'b0;
	logic echo_in = 1'b0;
	logic conn1 = 1'b1;
	logic rx1p, rx1n, rx2p, rx2n, tx1p, tx1n, tx2p, tx2n, echo_out;
	logic [7:0] lamp;
	int n_errors = 0;
	int n_compared = 0;

	bst_selftest_top #(.SHOW_CYCLES(SHOW), .STEP_CYCLES(STEP), .FLASH_CYCLES(FLASH),
		.HOLD_CYCLES(HOLD)) bst_selftest_top_inst (
		.CLOCK_IN(clk), .RSTN_IN(rstn), .RESET_PUSHBUTTON_IN(b_rst),
		.ALL_ON_PUSHBUTTON_IN(b_on), .ALL_OFF_PUSHBUTTON_IN(b_off),
		.COUNT_PUSHBUTTON_IN(b_cnt), .LOOP_ONE_DIFF_RX_P_IN(rx1p),
		.LOOP_ONE_DIFF_RX_N_IN(rx1n), .LOOP_TWO_DIFF_RX_P_IN(rx2p),
		.LOOP_TWO_DIFF_RX_N_IN(rx2n), .SERIAL_ECHO_IN(echo_in),
		.LOOP_ONE_DIFF_TX_P_OUT(tx1p), .LOOP_ONE_DIFF_TX_N_OUT(tx1n),
		.LOOP_TWO_DIFF_TX_P_OUT(tx2p), .LOOP_TWO_DIFF_TX_N_OUT(tx2n),
		.SERIAL_ECHO_OUT(echo_out), .LAMP_DRIVE_OUT(lamp));
	bst_loop_partner bst_loop_partner_inst (.clk_in(clk), .connect_in(conn1),
		.tx_p_in(tx1p), .tx_n_in(tx1n), .rx_p_out(rx1p), .rx_n_out(rx1n));
	bst_loop_partner bst_loop_partner_two_inst (.clk_in(clk), .connect_in(1'b1),
		.tx_p_in(tx2p), .tx_n_in(tx2n), .rx_p_out(rx2p), .rx_n_out(rx2n));

	initial begin
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic ok, input string what);
		n_compared++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wait_lamp(input logic [7:0] mask, input logic [7:0] val, input int bound);
		int i;
		for (i = 0; i < bound && (lamp & mask) !== val; i++) begin
			cyc(1);
		end
		if ((lamp & mask) !== val) begin
			n_errors++;
			$display("[FAIL] %0t lamps never reached %h", $time, val);
			report_and_stop();
		end
	endtask

	task automatic flashes(output int n1, output int n2);
		logic [1:0] last;
		n1 = 0;
		n2 = 0;
		last = lamp[7:6];
		repeat (64) begin
			cyc(1);
			n1 += int'(lamp[7] !== last[1]);
			n2 += int'(lamp[6] !== last[0]);
			last = lamp[7:6];
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		check(lamp === 8'hff && tx1p === 1'b0 && tx1n === 1'b1, "reset lamps");
		@(posedge clk) rstn <= 1'b1;
		cyc(1);
		check(lamp === 8'hc0, "lamps after release");
		wait_lamp(8'h3e, 8'h02, STEP + 4);
		check(lamp[7:6] === 2'b11, "status lamps held on");
		@(posedge clk) begin
			b_rst <= 1'b1;
			b_off <= 1'b1;
		end
		#1 check(lamp === 8'hff, "reset button beats all-off");
		@(posedge clk) begin
			b_rst <= 1'b0;
			b_off <= 1'b0;
		end
		cyc(1);
		check(lamp[5:0] === 6'h00, "lamps after button reset");
		$display("test reset done");
	endtask

	task automatic t_echo();
		@(posedge clk) echo_in <= 1'b1;
		#1 check(echo_out === 1'b1, "echo high");
		@(posedge clk) echo_in <= 1'b0;
		#1 check(echo_out === 1'b0, "echo low");
		$display("test echo done");
	endtask

	task automatic t_pattern();
		logic [19:0] s1;
		logic [19:0] s2;
		logic [1:0] found;
		int k;
		found = 2'b00;
		for (k = 0; k < 20; k++) begin
			cyc(1);
			s1 = {s1[18:0], tx1p};
			s2 = {s2[18:0], tx2p};
			check(tx1n === ~tx1p && tx2n === ~tx2p, "pair polarity");
		end
		for (k = 0; k < 10; k++) begin
			found[0] |= (s1[19-k -: 10] === 10'h173);
			found[1] |= (s2[19-k -: 10] === 10'h173);
		end
		check(found === 2'b11 && s1[19:10] === s1[9:0] && s2[19:10] === s2[9:0], "pattern");
		$display("test pattern done");
	endtask

	task automatic t_show(input logic off, input logic [7:0] forced, input logic [4:0] shown);
		int n;
		@(posedge clk) begin
			b_on <= 1'b1;
			b_off <= off;
		end
		#1 check(lamp === forced, "forced lamps");
		cyc(3);
		check(lamp === forced, "forced lamps held");
		@(posedge clk) begin
			b_on <= 1'b0;
			b_off <= 1'b0;
		end
		#1 wait_lamp(8'h3e, {2'h0, shown, 1'b0}, 4);
		n = 0;
		while (lamp[5:1] === shown && n < SHOW + 4) begin
			cyc(1);
			n++;
		end
		check(n >= SHOW - 2 && n <= SHOW + 2, "display length");
		cyc(2 * STEP);
		check(lamp[5:1] === 5'h00, "display back to zero");
		$display("test show %0d done", off);
	endtask

	task automatic t_count();
		logic [4:0] prev;
		int n;
		int k;
		@(posedge clk) b_cnt <= 1'b1;
		@(posedge clk) b_cnt <= 1'b0;
		cyc(2);
		prev = lamp[5:1];
		n = 0;
		while (lamp[5:1] === prev && n < STEP + 2) begin
			cyc(1);
			n++;
		end
		check(lamp[5:1] === prev + 5'h01, "count resumes");
		for (k = 0; k < 40; k++) begin
			prev = lamp[5:1];
			n = 0;
			while (lamp[5:1] === prev && n < STEP + 2) begin
				cyc(1);
				n++;
			end
			check(lamp[5:1] === prev + 5'h01 && n == STEP, "count step");
		end
		$display("test count done");
	endtask

	task automatic t_loop();
		int n1;
		int n2;
		flashes(n1, n2);
		check(n1 >= 7 && n1 <= 9 && n2 >= 7 && n2 <= 9, "both lamps flash");
		@(posedge clk) conn1 <= 1'b0;
		cyc(40 + FLASH + 4);
		flashes(n1, n2);
		check(n1 == 0 && lamp[7] === 1'b0 && n2 >= 7, "open link lamp off");
		@(posedge clk) conn1 <= 1'b1;
		cyc(60);
		flashes(n1, n2);
		check(n1 >= 7 && n1 <= 9, "relinked lamp flashes");
		$display("test loop done");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		#1;
		t_reset();
		t_echo();
		t_pattern();
		t_show(1'b0, 8'hfe, 5'h0a);
		t_count();
		t_show(1'b1, 8'h00, 5'h15);
		t_loop();
		report_and_stop();
	end
endmodule // board_selftest_switch_led_loopback_tb_top
